// *** cag_consts.svh ***
`ifndef CAG_CONSTS_SVH
`define CAG_CONSTS_SVH
// APB byte offsets of the ring registers.
`define CAG_OFF_MODE_CTRL 12'h046
`define CAG_OFF_X_START 12'h048
`define CAG_OFF_X_END 12'h04a
`define CAG_OFF_Y_START 12'h04c
`define CAG_OFF_Y_END 12'h04e
// Mode control field positions.
`define CAG_X_SEL_LSB 0
`define CAG_Y_SEL_LSB 4
`define CAG_Y_EN_BIT 14
`define CAG_X_EN_BIT 15
// Pointer select value that disables a ring.
`define CAG_SEL_OFF 4'hf
// Reset values.
`define CAG_RST_MODE_CTRL 16'h0000
`define CAG_RST_BOUND 16'h0000
`endif

// *** cag_pkg.sv ***
package cag_pkg;
  // Address calculation modes requested by the decoder.
  typedef enum logic [2:0] {
    CAG_M_INDIRECT,
    CAG_M_POST_MOD,
    CAG_M_PRE_MOD,
    CAG_M_REG_OFFSET,
    CAG_M_LIT_OFFSET
  } cag_mode_t;
  // Instruction class seen by the generator.
  typedef enum logic [1:0] {
    CAG_C_GENERAL,
    CAG_C_MOVE_ACC,
    CAG_C_MAC
  } cag_class_t;
endpackage

// *** cag_ring.sv ***
`timescale 1ns/1ns
`default_nettype none
module cag_ring #(
  parameter int AW = 16
) (
  input wire logic [AW-1:0] i_addr,
  input wire logic [AW-1:0] i_start,
  input wire logic [AW-1:0] i_end,
  input wire logic i_active,
  input wire logic i_down,
  input wire logic i_both,
  output logic [AW-1:0] o_addr
);
  // Ring length in bytes: the end bound names the last byte of the last word.
  logic [AW-1:0] len;
  always_comb begin
    len = AW'(i_end - i_start + AW'(1));
    o_addr = i_addr;
    if (i_active) begin
      if ((!i_down || i_both) && (i_addr > i_end)) begin
        o_addr = AW'(i_addr - len);
      end else if ((i_down || i_both) && (i_addr < i_start)) begin
        o_addr = AW'(i_addr + len);
      end
    end
  end
endmodule
`default_nettype wire

// *** cag_top.sv ***
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "cag_consts.svh"
module cag_top
  import cag_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic i_ce,
  input wire logic [11:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_req,
  input wire cag_class_t i_class,
  input wire cag_mode_t i_mode,
  input wire logic [3:0] i_ptr_num,
  input wire logic [AW-1:0] i_ptr_val,
  input wire logic [AW-1:0] i_offset_val,
  input wire logic signed [AW-1:0] i_modifier,
  input wire logic i_is_write,
  input wire logic i_branch,
  input wire logic [15:0] i_branch_lit,
  input wire logic [AW-1:0] i_pc,
  input wire logic i_hold,
  input wire logic [13:0] i_hold_lit,
  output logic o_valid,
  output logic [AW-1:0] o_ea,
  output logic o_ea_y,
  output logic o_wb_en,
  output logic [3:0] o_wb_num,
  output logic [AW-1:0] o_wb_val,
  output logic o_illegal,
  output logic o_branch_valid,
  output logic [AW-1:0] o_branch_target,
  output logic o_hold_valid,
  output logic [13:0] o_hold_count
);
  // All state of the block in one record.
  typedef struct packed {
    logic [15:0] mode_ctrl_r;
    logic [AW-1:0] x_start_r;
    logic [AW-1:0] x_end_r;
    logic [AW-1:0] y_start_r;
    logic [AW-1:0] y_end_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic valid_r;
    logic [AW-1:0] ea_r;
    logic ea_y_r;
    logic wb_en_r;
    logic [3:0] wb_num_r;
    logic [AW-1:0] wb_val_r;
    logic illegal_r;
    logic br_valid_r;
    logic [AW-1:0] br_target_r;
    logic hold_valid_r;
    logic [13:0] hold_count_r;
  } cag_state_t;

  cag_state_t st_r; // Registered state.
  cag_state_t st_nxt; // Next state.

  logic [3:0] x_sel; // X ring pointer select.
  logic [3:0] y_sel; // Y ring pointer select.
  logic x_ring_enable; // X ring enable bit.
  logic y_ring_enable; // Y ring enable bit.
  logic use_y; // Request goes to the Y generator.
  logic ring_hit; // Pointer matches its ring select.
  logic [AW-1:0] raw_ea; // Address before ring correction.
  logic [AW-1:0] new_ptr; // Modified pointer before correction.
  logic [AW-1:0] fix_ea; // Address after ring correction.
  logic [AW-1:0] fix_ptr; // Pointer after ring correction.
  logic [AW-1:0] sel_start; // Start bound of the chosen ring.
  logic [AW-1:0] sel_end; // End bound of the chosen ring.
  logic ring_active; // Chosen ring is enabled and selected.
  logic down; // Pointer is moving downward.
  logic pow2; // Ring length is a power of two.
  logic [AW-1:0] ring_len; // Ring length for the power-of-two test.
  logic mac_bad; // Request breaks the MAC addressing limits.
  logic apb_acc; // APB access phase.
  logic [AW-1:0] span_ea; // Address used by the pointer corrector.

  // Control fields.
  // X and Y select and enable, and the APB access phase.
  assign x_sel = st_r.mode_ctrl_r[`CAG_X_SEL_LSB +: 4];
  assign x_ring_enable = st_r.mode_ctrl_r[`CAG_X_EN_BIT];
  assign y_sel = st_r.mode_ctrl_r[`CAG_Y_SEL_LSB +: 4];
  assign y_ring_enable = st_r.mode_ctrl_r[`CAG_Y_EN_BIT];
  assign apb_acc = i_psel && i_penable;

  // Address space routing, mode decode and ring selection.
  always_comb begin
    // MAC pointers 10, 11 go to Y.
    use_y = (i_class == CAG_C_MAC) && (i_ptr_num[3:1] == 3'b101);
    if (use_y) begin
      ring_hit = (i_ptr_num == y_sel) && (y_sel != `CAG_SEL_OFF) && y_ring_enable;
      sel_start = st_r.y_start_r;
      sel_end = st_r.y_end_r;
    end else begin
      ring_hit = (i_ptr_num == x_sel) && (x_sel != `CAG_SEL_OFF) && x_ring_enable;
      sel_start = st_r.x_start_r;
      sel_end = st_r.x_end_r;
    end
    ring_active = ring_hit;
    down = i_modifier[AW-1];
    // Full 16-bit span covers 32K words.
    ring_len = AW'(sel_end - sel_start + AW'(1));
    pow2 = ((ring_len & AW'(ring_len - AW'(1))) == '0);
    new_ptr = AW'(i_ptr_val + AW'(i_modifier));
    raw_ea = i_ptr_val;
    unique case (i_mode)
      CAG_M_INDIRECT: raw_ea = i_ptr_val;
      CAG_M_POST_MOD: raw_ea = i_ptr_val;
      CAG_M_PRE_MOD: raw_ea = new_ptr;
      CAG_M_REG_OFFSET: raw_ea = AW'(i_ptr_val + i_offset_val);
      CAG_M_LIT_OFFSET: raw_ea = AW'(i_ptr_val + i_offset_val);
      default: raw_ea = i_ptr_val;
    endcase
    span_ea = (i_mode == CAG_M_POST_MOD) ? new_ptr : raw_ea;
    // MAC limits on pointers, modes and post-modify steps.
    mac_bad = 1'b0;
    if (i_class == CAG_C_MAC) begin
      if (i_ptr_num[3:2] != 2'b10) begin
        mac_bad = 1'b1;
      end
      unique case (i_mode)
        CAG_M_INDIRECT: mac_bad = mac_bad;
        CAG_M_POST_MOD: begin
          if (!(i_modifier == AW'(2) || i_modifier == AW'(4) || i_modifier == AW'(6) ||
                i_modifier == -AW'(2) || i_modifier == -AW'(4) ||
                i_modifier == -AW'(6))) begin
            mac_bad = 1'b1;
          end
        end
        // Indexed only with 9 and 11.
        CAG_M_REG_OFFSET: begin
          if (!(i_ptr_num == 4'h9 || i_ptr_num == 4'hb)) begin
            mac_bad = 1'b1;
          end
        end
        default: mac_bad = 1'b1;
      endcase
      // Writes never use the MAC read path.
      if (i_is_write) begin
        mac_bad = 1'b1;
      end
    end
  end

  // Ring corrector for the effective address.
  cag_ring #(
    .AW(AW)
  ) u_ring_ea (
    .i_addr(raw_ea),
    .i_start(sel_start),
    .i_end(sel_end),
    .i_active(ring_active),
    .i_down(down),
    .i_both(pow2),
    .o_addr(fix_ea)
  );

  // Ring corrector for the post-modified pointer.
  cag_ring #(
    .AW(AW)
  ) u_ring_ptr (
    .i_addr(span_ea),
    .i_start(sel_start),
    .i_end(sel_end),
    .i_active(ring_active),
    .i_down(down),
    .i_both(pow2),
    .o_addr(fix_ptr)
  );

  // Next-state logic for the bus slave and the address pipeline.
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready_r = 1'b0;
    st_nxt.pslverr_r = 1'b0;
    // APB answers one cycle after the access phase starts.
    if (apb_acc && !st_r.pready_r) begin
      st_nxt.pready_r = 1'b1;
      st_nxt.prdata_r = 32'h00000000;
      unique case (i_paddr)
        `CAG_OFF_MODE_CTRL: begin
          if (i_pwrite) begin
            st_nxt.mode_ctrl_r = {i_pwdata[15:14], 6'h00, i_pwdata[7:0]};
          end
          st_nxt.prdata_r = {16'h0000, st_r.mode_ctrl_r};
        end
        `CAG_OFF_X_START: begin
          if (i_pwrite) begin
            st_nxt.x_start_r = i_pwdata[AW-1:0];
          end
          st_nxt.prdata_r = 32'(st_r.x_start_r);
        end
        `CAG_OFF_X_END: begin
          if (i_pwrite) begin
            st_nxt.x_end_r = i_pwdata[AW-1:0];
          end
          st_nxt.prdata_r = 32'(st_r.x_end_r);
        end
        `CAG_OFF_Y_START: begin
          if (i_pwrite) begin
            st_nxt.y_start_r = {i_pwdata[AW-1:1], 1'b0};
          end
          st_nxt.prdata_r = 32'(st_r.y_start_r);
        end
        `CAG_OFF_Y_END: begin
          if (i_pwrite) begin
            st_nxt.y_end_r = {i_pwdata[AW-1:1], 1'b1};
          end
          st_nxt.prdata_r = 32'(st_r.y_end_r);
        end
        default: begin
          // Unmapped address answers with an error.
          st_nxt.pslverr_r = 1'b1;
        end
      endcase
    end
    // Valid, write-back enable and illegal flags are one-cycle pulses; the address and pointer number hold.
    st_nxt.valid_r = 1'b0;
    st_nxt.wb_en_r = 1'b0;
    st_nxt.illegal_r = 1'b0;
    if (i_req) begin
      st_nxt.valid_r = !mac_bad;
      st_nxt.illegal_r = mac_bad;
      st_nxt.ea_y_r = use_y;
      st_nxt.ea_r = fix_ea;
      if (use_y) begin
        st_nxt.ea_r = {fix_ea[AW-1:1], 1'b0};
      end
      st_nxt.wb_num_r = i_ptr_num;
      if (!mac_bad && (i_mode == CAG_M_POST_MOD || i_mode == CAG_M_PRE_MOD)) begin
        st_nxt.wb_en_r = 1'b1;
        st_nxt.wb_val_r = use_y ? {fix_ptr[AW-1:1], 1'b0} : fix_ptr;
      end
    end
    st_nxt.br_valid_r = i_branch;
    if (i_branch) begin
      st_nxt.br_target_r = AW'(i_pc + AW'(signed'(i_branch_lit)));
    end
    st_nxt.hold_valid_r = i_hold;
    if (i_hold) begin
      st_nxt.hold_count_r = i_hold_lit;
    end
  end

  // State register with clock enable and asynchronous reset.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_r <= '0;
      st_r.mode_ctrl_r <= `CAG_RST_MODE_CTRL;
      st_r.x_start_r <= `CAG_RST_BOUND;
      st_r.x_end_r <= `CAG_RST_BOUND;
      st_r.y_start_r <= `CAG_RST_BOUND;
      st_r.y_end_r <= `CAG_RST_BOUND;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record.
  assign o_prdata = st_r.prdata_r;
  assign o_pready = st_r.pready_r;
  assign o_pslverr = st_r.pslverr_r;
  assign o_valid = st_r.valid_r;
  assign o_ea = st_r.ea_r;
  assign o_ea_y = st_r.ea_y_r;
  assign o_wb_en = st_r.wb_en_r;
  assign o_wb_num = st_r.wb_num_r;
  assign o_wb_val = st_r.wb_val_r;
  assign o_illegal = st_r.illegal_r;
  assign o_branch_valid = st_r.br_valid_r;
  assign o_branch_target = st_r.br_target_r;
  assign o_hold_valid = st_r.hold_valid_r;
  assign o_hold_count = st_r.hold_count_r;
endmodule
`default_nettype wire

// *** cag_top_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// Watches the generator ports and ties each answer to the request before it.
module cag_top_chk
  import cag_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic i_ce,
  input wire logic i_req,
  input wire cag_class_t i_class,
  input wire cag_mode_t i_mode,
  input wire logic [3:0] i_ptr_num,
  input wire logic i_branch,
  input wire logic [15:0] i_branch_lit,
  input wire logic [AW-1:0] i_pc,
  input wire logic o_valid,
  input wire logic o_illegal,
  input wire logic o_wb_en,
  input wire logic [3:0] o_wb_num,
  input wire logic [AW-1:0] o_ea,
  input wire logic o_ea_y,
  input wire logic o_branch_valid,
  input wire logic [AW-1:0] o_branch_target
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  // A request taken at this edge, and the dual-operand kind of it.
  wire logic rq = i_req && i_ce;
  wire logic mac = rq && (i_class == CAG_C_MAC);
  a_req_answer: assert property (rq |=> o_valid != o_illegal)
    else $error("request got no single answer");
  a_mac_ptr_set: assert property (mac && i_ptr_num[3:2] != 2'h2 |=> o_illegal)
    else $error("bad dual-operand pointer accepted");
  a_mac_x_route: assert property (mac && i_ptr_num[3:1] == 3'h4 |=> o_illegal || !o_ea_y)
    else $error("pointer 8 or 9 not routed to X");
  a_mac_y_word: assert property (mac && i_ptr_num[3:1] == 3'h5 |=>
    o_illegal || (o_ea_y && !o_ea[0])) else $error("Y address not a word in Y");
  a_mac_index: assert property (mac && i_mode == CAG_M_REG_OFFSET && !i_ptr_num[0]
    |=> o_illegal) else $error("indexed mode on wrong pointer");
  a_mac_modes: assert property (mac && i_mode inside {CAG_M_PRE_MOD, CAG_M_LIT_OFFSET}
    |=> o_illegal) else $error("forbidden dual-operand mode accepted");
  a_offset_keep: assert property (rq && !(i_mode inside {CAG_M_POST_MOD, CAG_M_PRE_MOD})
    |=> !o_wb_en) else $error("pointer written by offset mode");
  a_wb_target: assert property (rq && i_mode inside {CAG_M_POST_MOD, CAG_M_PRE_MOD} |=>
    o_illegal || (o_wb_en && o_wb_num == $past(i_ptr_num))) else $error("write-back wrong");
  a_branch_sum: assert property (i_branch && i_ce |=> o_branch_valid &&
    o_branch_target == $past(i_pc) + $past(i_branch_lit)) else $error("branch target wrong");
  c_y_read: cover property (mac && i_ptr_num == 4'hb ##1 o_valid);
  c_write_back: cover property (rq && i_mode == CAG_M_POST_MOD ##1 o_wb_en);
  c_refused: cover property (mac ##1 o_illegal);
endmodule
`default_nettype wire

// *** cag_wreg_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Working register file of the core; serves pointers, takes write-backs.
module cag_wreg_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_num,
  input wire logic i_wb_en,
  input wire logic [3:0] i_wb_num,
  input wire logic [15:0] i_wb_val,
  output logic [15:0] o_val
);
  logic [15:0] w_r [16];
  assign o_val = w_r[i_num];
  // Pointer n resets to 0x1100 plus 16 n; write-backs land at the edge.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 16; i++) w_r[i] <= 16'h1100 + 16'(i * 16);
    end else if (i_wb_en) begin
      w_r[i_wb_num] <= i_wb_val;
    end
  end
endmodule
`default_nettype wire

// *** test_circular_address_generator.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_circular_address_generator
  import cag_pkg::*;
;
  // One request row: inputs, then flags {refused, Y, write-back} and values.
  typedef struct {
    cag_class_t c; cag_mode_t m; logic [3:0] p; logic [15:0] off; logic [15:0] md;
    logic [2:0] f; logic [15:0] ea; logic [15:0] wv;
  } cag_row_t;
  logic I_CLOCK = 1'h0, I_RSTN = 1'h0, i_ce = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
  logic i_pwrite = 1'h0, i_req = 1'h0, i_is_write = 1'h0, i_branch = 1'h0, i_hold = 1'h0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, o_valid, o_ea_y, o_wb_en, o_illegal, o_branch_valid, o_hold_valid;
  cag_class_t i_class = CAG_C_GENERAL;
  cag_mode_t i_mode = CAG_M_INDIRECT;
  logic [3:0] i_ptr_num = 4'h0, o_wb_num;
  logic [15:0] i_ptr_val, i_offset_val = 16'h0, i_modifier = 16'h0, i_branch_lit = 16'h0;
  logic [15:0] i_pc = 16'h0, o_ea, o_wb_val, o_branch_target;
  logic [13:0] i_hold_lit = 14'h0, o_hold_count;
  int fails = 0, num_checks = 0;
  cag_row_t rows[14] = '{
    '{CAG_C_MOVE_ACC, CAG_M_REG_OFFSET, 4'h2, 16'h10, 16'h0, 3'h0, 16'h1130, 16'h0},
    '{CAG_C_MOVE_ACC, CAG_M_POST_MOD, 4'h3, 16'h0, 16'h2, 3'h1, 16'h1130, 16'h1132},
    '{CAG_C_MOVE_ACC, CAG_M_PRE_MOD, 4'h4, 16'h0, 16'hfffc, 3'h1, 16'h113c, 16'h113c},
    '{CAG_C_MAC, CAG_M_INDIRECT, 4'h8, 16'h0, 16'h0, 3'h0, 16'h1180, 16'h0},
    '{CAG_C_MAC, CAG_M_INDIRECT, 4'ha, 16'h0, 16'h0, 3'h2, 16'h11a0, 16'h0},
    '{CAG_C_MAC, CAG_M_POST_MOD, 4'hb, 16'h0, 16'h6, 3'h3, 16'h11b0, 16'h11b6},
    '{CAG_C_MAC, CAG_M_POST_MOD, 4'h8, 16'h0, 16'hfffc, 3'h1, 16'h1180, 16'h117c},
    '{CAG_C_MAC, CAG_M_REG_OFFSET, 4'h9, 16'h4, 16'h0, 3'h0, 16'h1194, 16'h0},
    '{CAG_C_MAC, CAG_M_REG_OFFSET, 4'hb, 16'h3, 16'h0, 3'h2, 16'h11b8, 16'h0},
    '{CAG_C_MAC, CAG_M_REG_OFFSET, 4'h8, 16'h4, 16'h0, 3'h4, 16'h0, 16'h0},
    '{CAG_C_MAC, CAG_M_POST_MOD, 4'h9, 16'h0, 16'h8, 3'h4, 16'h0, 16'h0},
    '{CAG_C_MAC, CAG_M_INDIRECT, 4'h5, 16'h0, 16'h0, 3'h4, 16'h0, 16'h0},
    '{CAG_C_MAC, CAG_M_PRE_MOD, 4'h8, 16'h0, 16'h2, 3'h4, 16'h0, 16'h0},
    '{CAG_C_MAC, CAG_M_LIT_OFFSET, 4'h8, 16'h2, 16'h0, 3'h4, 16'h0, 16'h0}};
  // The clock toggles every half period of 50 ns.
  always #50 I_CLOCK = ~I_CLOCK;
  cag_top DUT (.I_CLOCK, .I_RSTN, .i_ce, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_req, .i_class, .i_mode, .i_ptr_num, .i_ptr_val,
    .i_offset_val, .i_modifier, .i_is_write, .i_branch, .i_branch_lit, .i_pc, .i_hold,
    .i_hold_lit, .o_valid, .o_ea, .o_ea_y, .o_wb_en, .o_wb_num, .o_wb_val, .o_illegal,
    .o_branch_valid, .o_branch_target, .o_hold_valid, .o_hold_count);
  cag_wreg_model WREG (.i_clk(I_CLOCK), .i_rstn(I_RSTN), .i_num(i_ptr_num), .i_wb_en(o_wb_en),
    .i_wb_num(o_wb_num), .i_wb_val(o_wb_val), .o_val(i_ptr_val));
  // Prints the verdict and ends the run.
  task test_done;
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound, keeps data and error.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge I_CLOCK);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge I_CLOCK);
    i_penable <= 1'h1;
    // Ready, error and read data are all taken at the rising edge that sees ready.
    do begin
      @(posedge I_CLOCK);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    if (o_pready !== 1'h1) begin
      fails++;
      test_done();
    end
    rd = {o_pslverr, o_prdata[30:0]};
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  // One address request; the answer stands in the cycle after.
  task go(input cag_row_t r);
    @(posedge I_CLOCK);
    i_req <= 1'h1;
    i_class <= r.c;
    i_mode <= r.m;
    i_ptr_num <= r.p;
    i_offset_val <= r.off;
    i_modifier <= r.md;
    @(posedge I_CLOCK);
    i_req <= 1'h0;
    @(negedge I_CLOCK);
    chk({o_valid, o_illegal, o_wb_en}, {!r.f[2], r.f[2], r.f[0]});
    if (!r.f[2]) chk({o_ea_y, o_ea}, {r.f[1], r.ea});
    if (r.f[0]) chk(o_wb_val, r.wv);
  endtask
  initial begin
    repeat (20) @(posedge I_CLOCK);
    I_RSTN <= 1'h1;
    foreach (rows[k]) go(rows[k]);
    apb(1'h0, 12'h046, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h046, 32'hffffffff);
    apb(1'h0, 12'h046, 32'h0);
    chk(rd, 32'hc0ff);
    apb(1'h1, 12'h050, 32'h1);
    chk(rd[31], 1'h1);
    // X ring of 64 bytes, first disabled by select 15, then on pointer 1.
    apb(1'h1, 12'h048, 32'h1100);
    apb(1'h1, 12'h04a, 32'h113f);
    apb(1'h1, 12'h046, 32'h800f);
    go('{CAG_C_MOVE_ACC, CAG_M_REG_OFFSET, 4'hf, 16'h0, 16'h0, 3'h0, 16'h11f0, 16'h0});
    apb(1'h1, 12'h046, 32'h8001);
    go('{CAG_C_MOVE_ACC, CAG_M_POST_MOD, 4'h1, 16'h0, 16'h2e, 3'h1, 16'h1110, 16'h113e});
    go('{CAG_C_MOVE_ACC, CAG_M_POST_MOD, 4'h1, 16'h0, 16'h4, 3'h1, 16'h113e, 16'h1102});
    go('{CAG_C_MOVE_ACC, CAG_M_PRE_MOD, 4'h1, 16'h0, 16'hfffc, 3'h1, 16'h113e, 16'h113e});
    go('{CAG_C_MOVE_ACC, CAG_M_REG_OFFSET, 4'h1, 16'h10, 16'h0, 3'h0, 16'h110e, 16'h0});
    // Y ring of 8 bytes on pointer 10.
    apb(1'h1, 12'h04c, 32'h11a0);
    apb(1'h1, 12'h04e, 32'h11a7);
    apb(1'h1, 12'h046, 32'h40a0);
    go('{CAG_C_MAC, CAG_M_POST_MOD, 4'ha, 16'h0, 16'h6, 3'h3, 16'h11a0, 16'h11a6});
    go('{CAG_C_MAC, CAG_M_POST_MOD, 4'ha, 16'h0, 16'h6, 3'h3, 16'h11a6, 16'h11a4});
    @(posedge I_CLOCK);
    i_branch <= 1'h1;
    i_pc <= 16'h1000;
    i_branch_lit <= 16'hfffe;
    i_hold <= 1'h1;
    i_hold_lit <= 14'h3fff;
    @(posedge I_CLOCK);
    i_branch <= 1'h0;
    i_hold <= 1'h0;
    @(negedge I_CLOCK);
    chk({o_branch_valid, o_branch_target}, {1'h1, 16'h0ffe});
    chk({o_hold_valid, o_hold_count}, {1'h1, 14'h3fff});
    // A second reset clears the control register again.
    @(posedge I_CLOCK);
    I_RSTN <= 1'h0;
    repeat (3) @(posedge I_CLOCK);
    I_RSTN <= 1'h1;
    apb(1'h0, 12'h046, 32'h0);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
bind cag_top cag_top_chk #(.AW(AW)) u_chk (.I_CLOCK, .I_RSTN, .i_ce, .i_req, .i_class,
  .i_mode, .i_ptr_num, .i_branch, .i_branch_lit, .i_pc, .o_valid, .o_illegal, .o_wb_en,
  .o_wb_num, .o_ea, .o_ea_y, .o_branch_valid, .o_branch_target);
`default_nettype wire
